// ===== pkg/eep_defines.vh
// constants shared by the serial eeprom slave engine
`ifndef EEP_DEFINES_VH
`define EEP_DEFINES_VH

// select byte field positions
`define EEP_SEL_RW 0
`define EEP_SEL_A16 1
`define EEP_SEL_STRAP_LOW 2
`define EEP_SEL_STRAP_HIGH 3
`define EEP_SEL_TYPE_HI 7
`define EEP_SEL_TYPE_LO 4
// device type field, arbitrary value
`define EEP_DEV_TYPE 4'h5

// bit slot counts within a byte frame
`define EEP_ACK_SLOT 4'h8
`define EEP_END_SLOT 4'h9

// engine reset values
`define EEP_ADDR_RST 17'h00000
`define EEP_SYNC_RST 5'h03

// timing: clock period and program cycle time, then cycles
`define EEP_CLK_PERIOD_NS 100
`define EEP_PROG_TIME_NS 5000000
`define EEP_PROG_CYCLES (`EEP_PROG_TIME_NS / `EEP_CLK_PERIOD_NS)

`endif

// ===== core/eep_page_buf.v
// page latch memory: 256 bytes, registered read data
`timescale 1ns/1ps
`default_nettype none
module eep_page_buf (
	input wire i_clk, // system clock
	input wire i_we, // write strobe
	input wire [7:0] i_waddr, // write byte index
	input wire [7:0] i_wdata, // write byte
	input wire [7:0] i_raddr, // read byte index
	output reg [7:0] o_rdata // read byte, one cycle later
);

reg [7:0] mem [0:255];

// write port and registered read port
always @(posedge i_clk) begin
	if (i_we) begin
		mem[i_waddr] <= i_wdata;
	end
	o_rdata <= mem[i_raddr];
end

endmodule // eep_page_buf
`default_nettype wire

// ===== core/eep_slave.v
// two-wire serial eeprom slave protocol engine with page latch and ecc
`timescale 1ns/1ps
`default_nettype none
`include "eep_defines.vh"

// Function
// - start is data falling with clock high; ignored while programming runs
// - stop is data rising with clock high; ends transfer, returns to standby
// - transmitter releases data after eight bits; receiver acks on ninth pulse
// - incoming data sampled on clock rising edge
// - select byte msb first; type and strap fields must match straps
// - select byte bit zero: one means read, zero means write
// - match gives ack in ninth slot; mismatch releases bus, goes standby
// - write: after select ack, take and ack two address bytes
// - 17-bit address: top bit from select, then high and low bytes
// - programming starts only on stop in slot after data byte ack
// - after programming, address counter points past last modified byte
// - while programming, data output off and all requests ignored
// - write protect high: data bytes nacked, nothing programmed
// - page write up to 256 bytes in one row; low byte increments
// - six check bits per four-byte word; single bit errors corrected
// - writing any byte rewrites its whole word and check bits
// - reads ignore write protect; counter increments after each byte
// - random read: dummy write address, repeated start, read select
// - current read returns byte at counter, then increments it
// - master ack gives next byte; counter wraps to zero at top
// - master nack after read byte: stop sending, go standby
// - write protect high still acks select and address bytes
// - straps compared against select bits three and two
module eep_slave #(
	parameter PROG_CYCLES = `EEP_PROG_CYCLES
) (
	input wire i_clk, // system clock
	input wire i_sys_rst, // async reset, active high
	input wire i_scl, // serial clock pin
	input wire i_sda, // serial data pin level
	input wire i_chip_strap_low, // chip enable strap, select bit 2
	input wire i_chip_strap_high, // chip enable strap, select bit 3
	input wire i_write_protect_input, // high blocks writes
	output reg o_sda_o, // data drive value, always low
	output reg o_sda_oe, // high while pulling data low
	output reg o_busy, // programming cycle running
	output reg o_mem_rd, // array word read strobe
	output reg o_mem_wr, // array word write strobe
	output reg [14:0] o_mem_addr, // array word address
	output reg [31:0] o_mem_wdata, // array write word
	output reg [5:0] o_mem_wcheck, // array write check bits
	input wire [31:0] i_mem_rdata, // array read word, cycle after strobe
	input wire [5:0] i_mem_rcheck // array read check bits
);

localparam S_IDLE = 6'h01;
localparam S_DEV = 6'h02;
localparam S_ADH = 6'h04;
localparam S_ADL = 6'h08;
localparam S_WDAT = 6'h10;
localparam S_RDAT = 6'h20;

localparam P_IDLE = 5'h01;
localparam P_FETCH = 5'h02;
localparam P_WAIT = 5'h04;
localparam P_MERGE = 5'h08;
localparam P_WRITE = 5'h10;

// check bits over hamming positions 3..38, parity at powers of two
function [5:0] eep_chk;
	input [31:0] d;
	integer k;
	integer p;
	reg [5:0] c;
	begin
		c = 6'h00;
		k = 0;
		for (p = 3; p < 39; p = p + 1) begin
			if ((p & (p - 1)) != 0) begin
				c = c ^ ({6{d[k]}} & p[5:0]);
				k = k + 1;
			end
		end
		eep_chk = c;
	end
endfunction

// flip the data bit whose position equals the syndrome
function [31:0] eep_fix;
	input [31:0] d;
	input [5:0] s;
	integer k;
	integer p;
	reg [31:0] r;
	begin
		r = d;
		k = 0;
		for (p = 3; p < 39; p = p + 1) begin
			if ((p & (p - 1)) != 0) begin
				if (s == p[5:0]) begin
					r[k] = ~d[k];
				end
				k = k + 1;
			end
		end
		eep_fix = r;
	end
endfunction

reg [4:0] meta_q;
reg [4:0] sync_q;
reg [4:0] prev_q;
reg [5:0] state_q;
reg [3:0] bitcnt_q;
reg [7:0] shin_q;
reg [7:0] shout_q;
reg ack_q;
reg rw_q;
reg a16_q;
reg [7:0] ahi_q;
reg [16:0] addr_q;
reg [8:0] row_q;
reg [7:0] wptr_q;
reg [7:0] next_ptr_q;
reg data_seen_q;
reg [255:0] mask_q;
reg [31:0] busy_cnt_q;
reg prog_go_q;
reg rd_req_q;
reg [1:0] rd_wait_q;
reg [7:0] rbyte_q;
reg buf_we_q;
reg [7:0] buf_waddr_q;
reg [7:0] buf_wdata_q;
reg [7:0] buf_raddr_q;
reg [4:0] pstate_q;
reg [5:0] pword_q;
reg [1:0] pbyte_q;
reg [31:0] wd_q;
reg [31:0] merged;
wire [7:0] buf_rdata;

// pins pass two flops; first stage feeds only the second
always @(posedge i_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		meta_q <= `EEP_SYNC_RST;
		sync_q <= `EEP_SYNC_RST;
		prev_q <= `EEP_SYNC_RST;
	end else begin
		meta_q <= {i_write_protect_input, i_chip_strap_high,
			i_chip_strap_low, i_sda, i_scl};
		sync_q <= meta_q;
		prev_q <= sync_q;
	end
end

wire scl = sync_q[0];
wire sda = sync_q[1];
wire strap_low = sync_q[2];
wire strap_high = sync_q[3];
wire wp = sync_q[4];
wire scl_rise = scl & ~prev_q[0];
wire scl_fall = ~scl & prev_q[0];
wire start_c = scl & prev_q[0] & prev_q[1] & ~sda;
wire stop_c = scl & prev_q[0] & ~prev_q[1] & sda;
wire [7:0] byte_w = {shin_q[6:0], sda};
wire sel_match = (byte_w[`EEP_SEL_TYPE_HI:`EEP_SEL_TYPE_LO] == `EEP_DEV_TYPE)
	& (byte_w[`EEP_SEL_STRAP_HIGH] == strap_high)
	& (byte_w[`EEP_SEL_STRAP_LOW] == strap_low);
wire [31:0] fixed_w = eep_fix(i_mem_rdata,
	eep_chk(i_mem_rdata) ^ i_mem_rcheck);

// protocol engine: framing, acks, shifting, address counter, busy
always @(posedge i_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		state_q <= S_IDLE;
		bitcnt_q <= 4'h0;
		shin_q <= 8'h00;
		shout_q <= 8'h00;
		ack_q <= 1'b0;
		rw_q <= 1'b0;
		a16_q <= 1'b0;
		ahi_q <= 8'h00;
		addr_q <= `EEP_ADDR_RST;
		row_q <= 9'h000;
		wptr_q <= 8'h00;
		next_ptr_q <= 8'h00;
		data_seen_q <= 1'b0;
		mask_q <= {256{1'b0}};
		busy_cnt_q <= 32'h00000000;
		prog_go_q <= 1'b0;
		rd_req_q <= 1'b0;
		rd_wait_q <= 2'h0;
		rbyte_q <= 8'h00;
		buf_we_q <= 1'b0;
		buf_waddr_q <= 8'h00;
		buf_wdata_q <= 8'h00;
		o_sda_o <= 1'b0;
		o_sda_oe <= 1'b0;
		o_busy <= 1'b0;
	end else begin
		o_sda_o <= 1'b0;
		prog_go_q <= 1'b0;
		rd_req_q <= 1'b0;
		buf_we_q <= 1'b0;
		// read data returns two cycles after the request
		if (rd_wait_q != 2'h0) begin
			rd_wait_q <= rd_wait_q - 2'h1;
		end
		if (rd_wait_q == 2'h1) begin
			rbyte_q <= fixed_w[{addr_q[1:0], 3'b000} +: 8];
			addr_q <= addr_q + 17'h00001;
		end
		if (o_busy) begin
			// deaf and released until the cycle count runs out
			o_sda_oe <= 1'b0;
			state_q <= S_IDLE;
			if (busy_cnt_q == PROG_CYCLES - 1) begin
				o_busy <= 1'b0;
				addr_q <= {row_q, next_ptr_q};
			end else begin
				busy_cnt_q <= busy_cnt_q + 32'h00000001;
			end
		end else if (start_c) begin
			state_q <= S_DEV;
			bitcnt_q <= 4'h0;
			o_sda_oe <= 1'b0;
		end else if (stop_c) begin
			state_q <= S_IDLE;
			o_sda_oe <= 1'b0;
			// the stop's own clock rise already counted slot one
			if (state_q == S_WDAT && bitcnt_q == 4'h1 && data_seen_q) begin
				o_busy <= 1'b1;
				busy_cnt_q <= 32'h00000000;
				prog_go_q <= 1'b1;
				next_ptr_q <= wptr_q;
			end
		end else if (scl_rise && state_q != S_IDLE) begin
			if (bitcnt_q < `EEP_ACK_SLOT) begin
				bitcnt_q <= bitcnt_q + 4'h1;
				if (state_q != S_RDAT) begin
					shin_q <= byte_w;
				end
				if (bitcnt_q == 4'h7) begin
					// full byte in: decide the answer for the ack slot
					case (state_q)
					S_DEV: begin
						ack_q <= sel_match;
						rw_q <= byte_w[`EEP_SEL_RW];
						if (!byte_w[`EEP_SEL_RW]) begin
							a16_q <= byte_w[`EEP_SEL_A16];
						end
						if (sel_match && byte_w[`EEP_SEL_RW]) begin
							rd_req_q <= 1'b1;
							rd_wait_q <= 2'h3;
						end
					end
					S_ADH: begin
						ack_q <= 1'b1;
						ahi_q <= byte_w;
					end
					S_ADL: begin
						ack_q <= 1'b1;
						addr_q <= {a16_q, ahi_q, byte_w};
						row_q <= {a16_q, ahi_q};
						wptr_q <= byte_w;
						mask_q <= {256{1'b0}};
						data_seen_q <= 1'b0;
					end
					S_WDAT: begin
						ack_q <= ~wp;
						if (!wp) begin
							buf_we_q <= 1'b1;
							buf_waddr_q <= wptr_q;
							buf_wdata_q <= byte_w;
							mask_q[wptr_q] <= 1'b1;
							wptr_q <= wptr_q + 8'h01;
							data_seen_q <= 1'b1;
						end
					end
					default: begin
						ack_q <= 1'b0;
					end
					endcase
				end
			end else if (bitcnt_q == `EEP_ACK_SLOT) begin
				bitcnt_q <= `EEP_END_SLOT;
				if (state_q == S_RDAT) begin
					if (sda) begin
						state_q <= S_IDLE;
					end else begin
						rd_req_q <= 1'b1;
						rd_wait_q <= 2'h3;
					end
				end
			end
		end else if (scl_fall && state_q != S_IDLE) begin
			if (bitcnt_q == `EEP_ACK_SLOT) begin
				if (state_q == S_RDAT) begin
					o_sda_oe <= 1'b0;
				end else if (!ack_q && state_q == S_DEV) begin
					state_q <= S_IDLE;
				end else begin
					o_sda_oe <= ack_q;
				end
			end else if (bitcnt_q == `EEP_END_SLOT) begin
				bitcnt_q <= 4'h0;
				o_sda_oe <= 1'b0;
				case (state_q)
				S_DEV: begin
					if (rw_q) begin
						state_q <= S_RDAT;
						shout_q <= rbyte_q;
						o_sda_oe <= ~rbyte_q[7];
					end else begin
						state_q <= S_ADH;
					end
				end
				S_ADH: begin
					state_q <= S_ADL;
				end
				S_ADL: begin
					state_q <= S_WDAT;
				end
				S_RDAT: begin
					shout_q <= rbyte_q;
					o_sda_oe <= ~rbyte_q[7];
				end
				default: begin
					state_q <= state_q;
				end
				endcase
			end else if (state_q == S_RDAT && bitcnt_q != 4'h0) begin
				// open drain: drive low only for a zero bit
				shout_q <= {shout_q[6:0], 1'b0};
				o_sda_oe <= ~shout_q[6];
			end
		end
	end
end

// merge one latched byte into the word being rebuilt
always @* begin
	merged = (pbyte_q == 2'h0) ? fixed_w : wd_q;
	if (mask_q[{pword_q, pbyte_q}]) begin
		merged[{pbyte_q, 3'b000} +: 8] = buf_rdata;
	end
end

// array port: read requests and the row program sequence
always @(posedge i_clk or posedge i_sys_rst) begin
	if (i_sys_rst) begin
		pstate_q <= P_IDLE;
		pword_q <= 6'h00;
		pbyte_q <= 2'h0;
		wd_q <= 32'h00000000;
		buf_raddr_q <= 8'h00;
		o_mem_rd <= 1'b0;
		o_mem_wr <= 1'b0;
		o_mem_addr <= 15'h0000;
		o_mem_wdata <= 32'h00000000;
		o_mem_wcheck <= 6'h00;
	end else begin
		o_mem_rd <= 1'b0;
		o_mem_wr <= 1'b0;
		if (rd_req_q) begin
			o_mem_rd <= 1'b1;
			o_mem_addr <= addr_q[16:2];
		end
		case (pstate_q)
		P_IDLE: begin
			pword_q <= 6'h00;
			if (prog_go_q) begin
				pstate_q <= P_FETCH;
			end
		end
		P_FETCH: begin
			o_mem_rd <= 1'b1;
			o_mem_addr <= {row_q, pword_q};
			buf_raddr_q <= {pword_q, 2'b00};
			pbyte_q <= 2'h0;
			pstate_q <= P_WAIT;
		end
		P_WAIT: begin
			buf_raddr_q <= buf_raddr_q + 8'h01;
			pstate_q <= P_MERGE;
		end
		P_MERGE: begin
			buf_raddr_q <= buf_raddr_q + 8'h01;
			wd_q <= merged;
			pbyte_q <= pbyte_q + 2'h1;
			if (pbyte_q == 2'h3) begin
				pstate_q <= P_WRITE;
			end
		end
		P_WRITE: begin
			if (mask_q[{pword_q, 2'b00} +: 4] != 4'h0) begin
				o_mem_wr <= 1'b1;
				o_mem_addr <= {row_q, pword_q};
				o_mem_wdata <= wd_q;
				o_mem_wcheck <= eep_chk(wd_q);
			end
			pword_q <= pword_q + 6'h01;
			pstate_q <= (pword_q == 6'h3F) ? P_IDLE : P_FETCH;
		end
		default: begin
			pstate_q <= P_IDLE;
		end
		endcase
	end
end

// page latch holding the bytes of the current row write
eep_page_buf u_page_buf (
	.i_clk(i_clk),
	.i_we(buf_we_q),
	.i_waddr(buf_waddr_q),
	.i_wdata(buf_wdata_q),
	.i_raddr(buf_raddr_q),
	.o_rdata(buf_rdata)
);

endmodule // eep_slave
`default_nettype wire

// ===== test/eep_slave_assertions.sv
// checker bound to the serial eeprom slave engine
`timescale 1ns/1ps
`default_nettype none
module eep_slave_assertions #(
	parameter PROG_CYCLES = 600
) (
	input wire logic i_clk, // clock
	input wire logic i_sys_rst, // reset
	input wire logic i_scl, // serial clock
	input wire logic i_write_protect_input, // write block
	input wire logic o_sda_oe, // data pull
	input wire logic o_busy, // programming
	input wire logic o_mem_rd, // array read
	input wire logic o_mem_wr // array write
);
	integer cnt_q;
	// counts programming cycles
	always @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			cnt_q <= 0;
		else
			cnt_q <= o_busy ? cnt_q + 1 : 0;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	property p_oe_busy; o_busy |-> !o_sda_oe; endproperty
	a_oe_busy: assert property (p_oe_busy)
		else $error("data pulled while busy");
	property p_busy_len; $fell(o_busy) |-> cnt_q == PROG_CYCLES; endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("busy length wrong");
	property p_busy_cap; cnt_q <= PROG_CYCLES; endproperty
	a_busy_cap: assert property (p_busy_cap)
		else $error("busy too long");
	property p_wr_busy; o_mem_wr |-> o_busy; endproperty
	a_wr_busy: assert property (p_wr_busy)
		else $error("array write outside programming");
	property p_rd_wr; !(o_mem_rd && o_mem_wr); endproperty
	a_rd_wr: assert property (p_rd_wr)
		else $error("array read and write together");
	property p_wp_prog; $rose(o_busy) |-> !i_write_protect_input; endproperty
	a_wp_prog: assert property (p_wp_prog)
		else $error("programming while protected");
	property p_oe_rise; $rose(o_sda_oe) |-> !i_scl; endproperty
	a_oe_rise: assert property (p_oe_rise)
		else $error("data pulled with clock high");
	property p_oe_hold; $rose(i_scl) |=> $stable(o_sda_oe)[*3]; endproperty
	a_oe_hold: assert property (p_oe_hold)
		else $error("data changed with clock high");
	property p_prog_stop;
		$rose(o_busy) |-> i_scl && $past(i_scl, 4);
	endproperty
	a_prog_stop: assert property (p_prog_stop)
		else $error("programming not after stop");
	c_busy: cover property ($rose(o_busy));
	c_ack: cover property ($rose(o_sda_oe));
	c_rd: cover property (o_mem_rd ##1 !o_mem_rd);
endmodule // eep_slave_assertions
bind eep_slave eep_slave_assertions #(.PROG_CYCLES(PROG_CYCLES)) chk_i (
	.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl(i_scl),
	.i_write_protect_input(i_write_protect_input), .o_sda_oe(o_sda_oe),
	.o_busy(o_busy), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr));
`default_nettype wire

// ===== test/eep_master_model.sv
// bus master model driving the serial clock and data line
`timescale 1ns/1ps
`default_nettype none
module eep_master_model (
	input wire logic i_sda, // resolved data line
	output logic o_scl, // serial clock
	output logic o_sda // data drive, high releases
);
	// idle bus: clock high, data released
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// one bit: data moves with clock low, sampled high
	task automatic bit_x(input logic b, output logic s);
		#100 o_sda = b;
		#300 o_scl = 1'b1;
		#200 s = i_sda;
		#200 o_scl = 1'b0;
	endtask
	// data falls while clock high
	task automatic start;
		o_sda = 1'b1;
		#400 o_scl = 1'b1;
		#400 o_sda = 1'b0;
		#400 o_scl = 1'b0;
	endtask
	// data rises while clock high
	task automatic stop;
		#100 o_sda = 1'b0;
		#300 o_scl = 1'b1;
		#400 o_sda = 1'b1;
		#400;
	endtask
	// byte out msb first, ninth slot released
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], s);
		bit_x(1'b1, s);
		ack = !s;
	endtask
	// byte in, then master ack or nack
	task automatic rd_byte(input logic mack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, s);
			d[i] = s;
		end
		bit_x(!mack, s);
	endtask
endmodule // eep_master_model
`default_nettype wire

// ===== test/eep_slave_tb_top.sv
// self-checking bench for the serial eeprom slave engine
`timescale 1ns/1ps
`default_nettype none
`include "eep_defines.vh"
module eep_slave_tb_top;
	localparam int PC = 600;
	logic i_clk = 1'b0, i_sys_rst = 1'b1, wp = 1'b0;
	logic oe, busy, rd_s, wr_s, scl, sda_m, sda_o;
	logic [1:0] strap = 2'h0;
	logic [14:0] maddr;
	logic [31:0] wdat, rdat = 32'h0;
	logic [5:0] wchk, rchk = 6'h0;
	bit [37:0] arr [int];
	int num_errors = 0, num_checks = 0, seed = 47, ptr = 0;
	int ref_mem [int];
	wire sda = sda_m & (sda_o | ~oe);
	always #50 i_clk = ~i_clk;
	// array: word stored, read word the cycle after the strobe
	always @(posedge i_clk) begin
		if (wr_s)
			arr[maddr] = {wchk, wdat};
		if (rd_s)
			{rchk, rdat} <= #1 arr.exists(maddr) ? arr[maddr] : 38'h0;
	end
	eep_master_model eep_master_model_i (.i_sda(sda), .o_scl(scl),
		.o_sda(sda_m));
	eep_slave #(.PROG_CYCLES(PC)) eep_slave_i (.i_clk(i_clk),
		.i_sys_rst(i_sys_rst), .i_scl(scl), .i_sda(sda),
		.i_chip_strap_low(strap[0]), .i_chip_strap_high(strap[1]),
		.i_write_protect_input(wp), .o_sda_o(sda_o),
		.o_sda_oe(oe), .o_busy(busy),
		.o_mem_rd(rd_s), .o_mem_wr(wr_s), .o_mem_addr(maddr),
		.o_mem_wdata(wdat), .o_mem_wcheck(wchk), .i_mem_rdata(rdat),
		.i_mem_rcheck(rchk));
	function automatic logic [7:0] sel(input logic rw, input logic a16);
		return {`EEP_DEV_TYPE, strap, a16, rw};
	endfunction
	task automatic chk(input string n, input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s exp %0h got %0h", n, e, s);
		end
	endtask
	task automatic end_sim;
		if (num_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// address load: write select, high then low byte
	task automatic load(input logic [16:0] a);
		logic k;
		eep_master_model_i.start;
		eep_master_model_i.wr_byte(sel(1'b0, a[16]), k);
		chk("sel ack", k, 1);
		eep_master_model_i.wr_byte(a[15:8], k);
		chk("hi ack", k, 1);
		eep_master_model_i.wr_byte(a[7:0], k);
		chk("lo ack", k, 1);
		ptr = a;
	endtask
	// page write of random bytes, then polling until ready
	task automatic wr(input logic [16:0] a, input int n);
		logic k;
		logic [7:0] d;
		load(a);
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			eep_master_model_i.wr_byte(d, k);
			chk("data ack", k, !wp);
			if (!wp)
				ref_mem[{a[16:8], a[7:0] + 8'(i)}] = d;
		end
		eep_master_model_i.stop;
		chk("busy", busy, !wp);
		if (!wp)
			ptr = {a[16:8], a[7:0] + 8'(n)};
		k = 1'b0;
		for (int i = 0; i < 40 && !k; i++) begin
			eep_master_model_i.start;
			eep_master_model_i.wr_byte(sel(1'b0, 1'b0), k);
			if (i == 0)
				chk("poll", k, wp);
		end
		eep_master_model_i.stop;
		chk("ready", k, 1);
	endtask
	// read from the counter, master nacks the last byte
	task automatic rd(input int n, input logic a16);
		logic k;
		logic [7:0] d;
		eep_master_model_i.start;
		eep_master_model_i.wr_byte(sel(1'b1, a16), k);
		chk("rsel ack", k, 1);
		for (int i = 0; i < n; i++) begin
			eep_master_model_i.rd_byte(i < n - 1, d);
			chk("rdata", d, ref_mem.exists(ptr) ? ref_mem[ptr] : 0);
			ptr = (ptr + 1) & 'h1FFFF;
		end
		eep_master_model_i.stop;
	endtask
	// main sequence
	initial begin
		logic k;
		logic [16:0] a;
		strap = 2'($random(seed));
		repeat (5) @(posedge i_clk);
		#1 i_sys_rst = 1'b0;
		repeat (3) @(posedge i_clk);
		#1;
		wr(17'h123FE, 4);
		load(17'h123FE);
		rd(2, 1'b1);
		rd(1, 1'b1);
		load(17'h12300);
		rd(2, 1'b1);
		wr(17'h12301, 1);
		load(17'h12300);
		rd(4, 1'b1);
		arr[32'h48C0][9] = ~arr[32'h48C0][9];
		load(17'h12300);
		rd(4, 1'b1);
		a = 17'($random(seed)) & 17'h1FF77;
		wr(a, 8);
		wr(a, 4);
		rd(4, a[16]);
		wp = 1'b1;
		wr(a, 2);
		load(a);
		rd(3, a[16]);
		wp = 1'b0;
		load(17'h1FFFF);
		rd(2, 1'b1);
		eep_master_model_i.start;
		eep_master_model_i.wr_byte({`EEP_DEV_TYPE, ~strap, 2'h0}, k);
		chk("bad strap", k, 0);
		eep_master_model_i.start;
		eep_master_model_i.wr_byte({~`EEP_DEV_TYPE, strap, 2'h0}, k);
		chk("bad type", k, 0);
		load(a);
		eep_master_model_i.stop;
		chk("no prog", busy, 0);
		// stop two slots into the byte after an accepted one
		load(a);
		eep_master_model_i.wr_byte(8'hC3, k);
		chk("data ack", k, 1);
		eep_master_model_i.bit_x(1'b0, k);
		eep_master_model_i.stop;
		chk("mid stop", busy, 0);
		chk("drive value", sda_o, 0);
		end_sim;
	end
	// watchdog against a hung transfer
	initial begin
		#3000000;
		num_errors++;
		end_sim;
	end
endmodule // eep_slave_tb_top
`default_nettype wire
